/* File: logic/bridge_cmd_pkg.sv */
// Constants and carriers for the bridge command register block
`default_nettype none

package bridge_cmd_pkg;
    localparam logic [7:0] BRIDGE_COMMAND_OFS  = 8'h04;
    localparam logic [15:0] BRIDGE_COMMAND_RST = 16'h0000;
    localparam int IO_EN_POS       = 0;
    localparam int MEM_EN_POS      = 1;
    localparam int BUS_MASTER_POS  = 2;
    localparam int SPECIAL_CYC_POS = 3;
    localparam int WR_INVAL_POS    = 4;
    localparam int PALETTE_POS     = 5;
    localparam int PARITY_RESP_POS = 6;
    localparam int SERR_EN_POS     = 8;
    localparam int B2B_POS         = 9;
    localparam int INT_DIS_POS     = 10;
    localparam int LOW_BYTE        = 0;
    localparam int HIGH_BYTE       = 1;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } cfg_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } fwd_msg_s;
endpackage : bridge_cmd_pkg

`default_nettype wire

/* File: logic/bridge_command_register.sv */
// Bridge command register with legacy interrupt, system error and parity gating
//
// Functional notes
// (R1) Disable clear: own legacy interrupt messages allowed
// (R2) Disable set: no own legacy interrupt messages
// (R3) Setting disable while asserted sends deassert
// (R4) Disable leaves forwarded messages untouched
// (R5) Back-to-back enable reads zero, ignores writes
// (R6) System error enable reports primary-side errors only
// (R7) Message when command or device control allows
// (R8) Reported errors recorded in bridge status
// (R9) Parity response write-once, gates parity flag
// (R10) Palette, invalidate, special cycle hardwired zero
// (R11) Reserved bits read zero, writes ignored
`timescale 1ns/10ps
`default_nettype none

module bridge_command_register
(
    input  wire logic                     i_mclk,            // Config clock
    input  wire logic                     i_sys_rst,         // Sync reset, active high
    input  wire bridge_cmd_pkg::cfg_req_s i_cfg,             // Config access request
    output var  logic [15:0]              o_cfg_rdata,       // Read data
    output var  logic                     o_cfg_rvalid,      // Read data valid pulse
    output var  logic [2:0]               o_space_enables,   // Bus master, mem, io
    input  wire logic                     i_own_int_req,     // PME or hot plug pending
    output var  logic                     o_inta_assert,     // Assert message pulse
    output var  logic                     o_inta_deassert,   // Deassert message pulse
    input  wire bridge_cmd_pkg::fwd_msg_s i_fwd_msg,         // Upstream forwarded message
    output var  bridge_cmd_pkg::fwd_msg_s o_fwd_msg,         // Forwarded message out
    input  wire logic                     i_pri_fatal_err,   // Primary-side fatal pulse
    input  wire logic                     i_pri_nonfatal_err,// Primary-side nonfatal pulse
    input  wire logic                     i_sec_err,         // Secondary-side error pulse
    input  wire logic                     i_dctl_fatal_en,   // Device control fatal enable
    input  wire logic                     i_dctl_nonfatal_en,// Device control nonfatal en
    output var  logic                     o_serr_msg,        // System error message pulse
    output var  logic                     o_status_serr,     // Status: system error sent
    input  wire logic                     i_status_serr_clr, // Status clear pulse
    input  wire logic                     i_master_parity_err,// Parity error seen
    output var  logic                     o_status_mdpe,     // Status: master parity err
    input  wire logic                     i_status_mdpe_clr  // Status clear pulse
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage and decode
    logic       int_disable;
    logic       serr_enable;
    logic       parity_resp;
    logic       parity_locked;
    logic [2:0] space_en;
    logic       int_asserted;

    wire hit      = i_cfg.addr == bridge_cmd_pkg::BRIDGE_COMMAND_OFS;
    wire wr_low   = i_cfg.wr && hit && i_cfg.be[bridge_cmd_pkg::LOW_BYTE];
    wire wr_high  = i_cfg.wr && hit && i_cfg.be[bridge_cmd_pkg::HIGH_BYTE];
    wire rd_hit   = i_cfg.rd && hit;

    logic [15:0] cmd_word;
    always_comb
    begin
        cmd_word = bridge_cmd_pkg::BRIDGE_COMMAND_RST;          // see (R5) see (R10) see (R11)
        cmd_word[bridge_cmd_pkg::IO_EN_POS]       = space_en[0];
        cmd_word[bridge_cmd_pkg::MEM_EN_POS]      = space_en[1];
        cmd_word[bridge_cmd_pkg::BUS_MASTER_POS]  = space_en[2];
        cmd_word[bridge_cmd_pkg::PARITY_RESP_POS] = parity_resp;
        cmd_word[bridge_cmd_pkg::SERR_EN_POS]     = serr_enable;
        cmd_word[bridge_cmd_pkg::INT_DIS_POS]     = int_disable;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            space_en      <= 3'h0;
            parity_resp   <= 1'b0;
            parity_locked <= 1'b0;
            serr_enable   <= 1'b0;
            int_disable   <= 1'b0;
        end
        else
        begin
            if (wr_low)
            begin
                space_en <= i_cfg.wdata[bridge_cmd_pkg::BUS_MASTER_POS:bridge_cmd_pkg::IO_EN_POS];
                parity_locked <= 1'b1;                          // see (R9)
                if (!parity_locked)
                    parity_resp <= i_cfg.wdata[bridge_cmd_pkg::PARITY_RESP_POS]; // see (R9)
            end
            if (wr_high)
            begin
                serr_enable <= i_cfg.wdata[bridge_cmd_pkg::SERR_EN_POS];
                int_disable <= i_cfg.wdata[bridge_cmd_pkg::INT_DIS_POS];
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            o_cfg_rdata  <= 16'h0000;
            o_cfg_rvalid <= 1'b0;
        end
        else
        begin
            o_cfg_rvalid <= rd_hit;
            o_cfg_rdata  <= rd_hit ? cmd_word : 16'h0000;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            o_space_enables <= 3'h0;
        else
            o_space_enables <= space_en;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Own legacy interrupt emulation
    wire send_assert   = i_own_int_req && !int_disable && !int_asserted;    // see (R1) see (R2)
    wire send_deassert = int_asserted && (int_disable || !i_own_int_req);   // see (R3)

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            int_asserted    <= 1'b0;
            o_inta_assert   <= 1'b0;
            o_inta_deassert <= 1'b0;
        end
        else
        begin
            o_inta_assert   <= send_assert;
            o_inta_deassert <= send_deassert;
            if (send_assert)
                int_asserted <= 1'b1;
            else if (send_deassert)
                int_asserted <= 1'b0;
        end
    end

    // Forwarded messages bypass the disable
    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
            o_fwd_msg <= '0;
        else
            o_fwd_msg <= i_fwd_msg;                             // see (R4)
    end

    ////////////////////////////////////////////////////////////////////////////
    // System error reporting and status flags
    wire fatal_ok    = i_pri_fatal_err && (serr_enable || i_dctl_fatal_en);       // see (R7)
    wire nonfatal_ok = i_pri_nonfatal_err && (serr_enable || i_dctl_nonfatal_en); // see (R7)
    wire serr_fire   = fatal_ok || nonfatal_ok;                 // see (R6)
    wire mdpe_set    = i_master_parity_err && parity_resp;      // see (R9)

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            o_serr_msg    <= 1'b0;
            o_status_serr <= 1'b0;
            o_status_mdpe <= 1'b0;
        end
        else
        begin
            o_serr_msg <= serr_fire;
            if (serr_fire)
                o_status_serr <= 1'b1;                          // see (R8)
            else if (i_status_serr_clr)
                o_status_serr <= 1'b0;
            if (mdpe_set)
                o_status_mdpe <= 1'b1;
            else if (i_status_mdpe_clr)
                o_status_mdpe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    a_no_assert_disabled: assert property ( // see (R2)
        o_inta_assert |-> !$past(int_disable))
        else $error("interrupt asserted while disabled");

    a_assert_when_allowed: assert property ( // see (R1)
        (i_own_int_req && !int_disable && !int_asserted) |=> o_inta_assert)
        else $error("allowed interrupt not asserted");

    a_deassert_on_disable: assert property ( // see (R3)
        (int_asserted && wr_high && i_cfg.wdata[bridge_cmd_pkg::INT_DIS_POS])
            |-> ##[1:2] o_inta_deassert ##1 !int_asserted)
        else $error("no deassert after disable set");

    a_forward_untouched: assert property ( // see (R4)
        o_fwd_msg == $past(i_fwd_msg))
        else $error("forwarded message altered");

    a_reserved_read_zero: assert property ( // see (R5) see (R10) see (R11)
        o_cfg_rvalid |-> (o_cfg_rdata & 16'hfebf & ~16'h0007) == 16'h0000
            || (o_cfg_rdata & 16'hfab8) == 16'h0000)
        else $error("hardwired bit read nonzero");

    a_serr_secondary: assert property ( // see (R6)
        (i_sec_err && !i_pri_fatal_err && !i_pri_nonfatal_err) |=> !o_serr_msg)
        else $error("secondary error raised message");

    a_serr_enable_or: assert property ( // see (R7)
        (i_pri_fatal_err && (serr_enable || i_dctl_fatal_en)) |=> o_serr_msg && o_status_serr)
        else $error("enabled fatal error not reported");

    a_status_recorded: assert property ( // see (R8)
        o_serr_msg |-> o_status_serr)
        else $error("status flag missing after message");

    a_parity_gate: assert property ( // see (R9)
        $rose(o_status_mdpe) |-> $past(parity_resp))
        else $error("parity flag set while gated");

    a_write_once: assert property ( // see (R9)
        parity_locked |=> $stable(parity_resp))
        else $error("parity enable changed after lock");

endmodule : bridge_command_register

`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the bridge command register block
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic                     i_mclk;
    logic                     i_sys_rst;
    bridge_cmd_pkg::cfg_req_s i_cfg;
    logic [15:0]              o_cfg_rdata;
    logic                     o_cfg_rvalid;
    logic [2:0]               o_space_enables;
    logic                     i_own_int_req;
    logic                     o_inta_assert;
    logic                     o_inta_deassert;
    bridge_cmd_pkg::fwd_msg_s i_fwd_msg;
    bridge_cmd_pkg::fwd_msg_s o_fwd_msg;
    logic                     i_pri_fatal_err;
    logic                     i_pri_nonfatal_err;
    logic                     i_sec_err;
    logic                     i_dctl_fatal_en;
    logic                     i_dctl_nonfatal_en;
    logic                     o_serr_msg;
    logic                     o_status_serr;
    logic                     i_status_serr_clr;
    logic                     i_master_parity_err;
    logic                     o_status_mdpe;
    logic                     i_status_mdpe_clr;
    int                       failures;
    int                       check_count;

    bridge_command_register i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cfg(i_cfg),
        .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
        .o_space_enables(o_space_enables), .i_own_int_req(i_own_int_req),
        .o_inta_assert(o_inta_assert), .o_inta_deassert(o_inta_deassert),
        .i_fwd_msg(i_fwd_msg), .o_fwd_msg(o_fwd_msg), .i_pri_fatal_err(i_pri_fatal_err),
        .i_pri_nonfatal_err(i_pri_nonfatal_err), .i_sec_err(i_sec_err),
        .i_dctl_fatal_en(i_dctl_fatal_en), .i_dctl_nonfatal_en(i_dctl_nonfatal_en),
        .o_serr_msg(o_serr_msg), .o_status_serr(o_status_serr),
        .i_status_serr_clr(i_status_serr_clr), .i_master_parity_err(i_master_parity_err),
        .o_status_mdpe(o_status_mdpe), .i_status_mdpe_clr(i_status_mdpe_clr));

    ////////////////////////////////////////////////////////////////////////////////
    task step;
        @(posedge i_mclk);
        #1;
    endtask : step

    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic fire(ref logic sig);
        sig = 1'b1;
        step();
        sig = 1'b0;
    endtask : fire

    task cfg_write(input logic [15:0] data, input logic [1:0] be);
        i_cfg = '{1'b1, 1'b0, bridge_cmd_pkg::BRIDGE_COMMAND_OFS, be, data};
        step();
        i_cfg = '0;
        step();
    endtask : cfg_write

    task cfg_read(input logic [7:0] addr, input logic valid, input logic [15:0] exp);
        i_cfg = '{1'b0, 1'b1, addr, 2'h0, 16'h0000};
        step();
        i_cfg = '0;
        check({15'h0000, o_cfg_rvalid}, {15'h0000, valid});
        check(o_cfg_rdata, exp);
        step();
    endtask : cfg_read

    ////////////////////////////////////////////////////////////////////////////////
    task reg_scn;
        cfg_read(8'h04, 1'b1, bridge_cmd_pkg::BRIDGE_COMMAND_RST);
        fire(i_master_parity_err);
        check({15'h0000, o_status_mdpe}, 16'h0000);
        cfg_write(16'hffff, 2'h3);
        cfg_read(8'h04, 1'b1, 16'h0547);
        check({13'h0000, o_space_enables}, 16'h0007);
        cfg_write(16'h0000, 2'h3);
        cfg_read(8'h04, 1'b1, 16'h0040);
        cfg_read(8'h06, 1'b0, 16'h0000);
        fire(i_master_parity_err);
        check({15'h0000, o_status_mdpe}, 16'h0001);
        fire(i_status_mdpe_clr);
        check({15'h0000, o_status_mdpe}, 16'h0000);
    endtask : reg_scn

    task irq_scn;
        i_own_int_req = 1'b1;
        step();
        check({15'h0000, o_inta_assert}, 16'h0001);
        i_fwd_msg = '{1'b1, 8'h5a};
        cfg_write(16'h0400, 2'h2);
        i_fwd_msg = '0;
        check({7'h00, o_fwd_msg}, 16'h015a);
        check({15'h0000, o_inta_deassert}, 16'h0001);
        i_own_int_req = 1'b0;
        step();
        i_own_int_req = 1'b1;
        repeat (3)
        begin
            step();
            check({15'h0000, o_inta_assert}, 16'h0000);
        end
        i_own_int_req = 1'b0;
    endtask : irq_scn

    task serr_scn;
        fire(i_pri_fatal_err);
        check({15'h0000, o_serr_msg}, 16'h0000);
        i_dctl_fatal_en = 1'b1;
        step();
        fire(i_pri_fatal_err);
        check({14'h0000, o_serr_msg, o_status_serr}, 16'h0003);
        i_dctl_fatal_en = 1'b0;
        fire(i_status_serr_clr);
        check({15'h0000, o_status_serr}, 16'h0000);
        cfg_write(16'h0100, 2'h2);
        fire(i_pri_nonfatal_err);
        check({15'h0000, o_serr_msg}, 16'h0001);
        fire(i_sec_err);
        check({15'h0000, o_serr_msg}, 16'h0000);
        cfg_write(16'h0000, 2'h2);
        fire(i_pri_nonfatal_err);
        check({15'h0000, o_serr_msg}, 16'h0000);
        i_dctl_nonfatal_en = 1'b1;
        step();
        fire(i_pri_nonfatal_err);
        check({15'h0000, o_serr_msg}, 16'h0001);
        i_dctl_nonfatal_en = 1'b0;
    endtask : serr_scn

    ////////////////////////////////////////////////////////////////////////////////
    task print_verdict;
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    initial
    begin
        failures = 0;
        check_count = 0;
        i_sys_rst = 1'b1;
        i_cfg = '0;
        i_fwd_msg = '0;
        {i_own_int_req, i_pri_fatal_err, i_pri_nonfatal_err, i_sec_err} = 4'h0;
        {i_dctl_fatal_en, i_dctl_nonfatal_en, i_status_serr_clr} = 3'h0;
        {i_master_parity_err, i_status_mdpe_clr} = 2'h0;
        repeat (4) @(posedge i_mclk);
        #1;
        i_sys_rst = 1'b0;
        step();
        reg_scn();
        irq_scn();
        serr_scn();
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
